/* hdl/counter_and_shift_chain_unit.sv */
// Purpose: Counter and shift chain evaluation unit, one operation per write.
// Assumes: The controller core writes one command per instruction per scan.
// Notes:   Registers are reached over Avalon-MM with waitrequest.

`timescale 1ns/1ps

module counter_and_shift_chain_unit
  import counter_chain_pkg::*;
#(
  parameter int unsigned COUNTERS = NUM_COUNTERS,
  parameter int unsigned RELAYS   = NUM_RELAYS
)(
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic [16:0] address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest
);
  localparam int unsigned NW = $clog2(COUNTERS);
  localparam int unsigned RW = $clog2(RELAYS);
  localparam int unsigned SW = NW - 4;
  localparam int unsigned QW = RW - 4;
  function automatic logic in_win(input logic [14:0] a,
                                  input logic [14:0] base,
                                  input int unsigned len);
    return (32'(a) >= 32'(base)) && (32'(a) < 32'(base) + len);
  endfunction
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (be[b])
        r[8*b +: 8] = nw[8*b +: 8];
    return r;
  endfunction

  // ********************************************************************
  // State
  // ********************************************************************
  logic [15:0]           vals_q [COUNTERS];
  logic [15:0]           vals_d [COUNTERS];
  logic [COUNTERS-1:0]   stat_q, stat_d;
  logic [COUNTERS-1:0]   prev_a_q, prev_a_d, prev_b_q, prev_b_d;
  logic [RELAYS-1:0]     relays_q, relays_d;
  logic [RELAYS/8-1:0]   prev_clk_q, prev_clk_d;
  chain_t                chain_q, chain_d;
  logic [31:0]           preset_q, preset_d;
  logic [1:0]            result_q, result_d;
  logic                  wait_q, wait_d;
  logic [31:0]           readdata_q, readdata_d;

  // ********************************************************************
  // Decode
  // ********************************************************************
  logic [14:0]   idx, voff, soff, roff;
  logic          req, wr_acc, exec_go, exec_ok;
  cmd_t          cmd;
  logic [NW-1:0] n, n1;
  logic [15:0]   cur16;
  logic [31:0]   cur32, limit;
  logic          edge_a, edge_b, preset_bad;
  logic [RW-1:0] f, l, lo, hi, entry;
  logic          up, chain_bad, clk_edge;
  assign idx    = address[16:2];
  assign voff   = idx - VALUE_BASE;
  assign soff   = idx - STATUS_BASE;
  assign roff   = idx - RELAY_BASE;
  assign req    = read | write;
  assign wr_acc = write & ~wait_q;
  assign cmd    = cmd_t'(writedata);
  assign n      = cmd.num[NW-1:0];
  // An up/down counter takes the next number too; the last one wraps.
  assign n1     = n + NW'(1);
  assign cur16  = vals_q[n];
  assign cur32  = {vals_q[n1], vals_q[n]};
  assign edge_a = cmd.in_a & ~prev_a_q[n];
  assign edge_b = cmd.in_b & ~prev_b_q[n];
  assign limit  = (cmd.kind == KIND_UPDOWN) ? UPDOWN_MAX
                                            : {16'h0000, COUNT_MAX};
  // Word and pointer presets arrive resolved; only constants are checked.
  assign preset_bad = ~cmd.preset_word & (preset_q > limit);
  assign f         = chain_q.first[RW-1:0];
  assign l         = chain_q.last[RW-1:0];
  assign up        = (f <= l);
  assign lo        = up ? f : l;
  assign hi        = up ? l : f;
  assign entry     = up ? lo : hi;
  assign chain_bad = (lo[2:0] != 3'h0) | (hi[2:0] != 3'h7);
  assign clk_edge  = cmd.in_b & ~prev_clk_q[f[RW-1:3]];
  assign exec_go = wr_acc & (idx == CMD_IDX) & (byteenable == 4'hf);
  assign exec_ok = exec_go & ((cmd.kind == KIND_SHIFT) ? ~chain_bad
                                                       : ~preset_bad);

  // ********************************************************************
  // Bus slave
  // ********************************************************************
  always_comb
  begin
    wait_d     = ~(req & wait_q);
    readdata_d = readdata_q;
    if (read && wait_q)
    begin
      readdata_d = 32'h00000000;
      if (in_win(idx, VALUE_BASE, COUNTERS))
        readdata_d[15:0] = vals_q[voff[NW-1:0]];
      else if (in_win(idx, STATUS_BASE, COUNTERS / 16))
        readdata_d[15:0] = stat_q[{soff[SW-1:0], 4'h0} +: 16];
      else if (in_win(idx, RELAY_BASE, RELAYS / 16))
        readdata_d[15:0] = relays_q[{roff[QW-1:0], 4'h0} +: 16];
      else if (idx == CHAIN_IDX)
        readdata_d = chain_q;
      else if (idx == PRESET_IDX)
        readdata_d = preset_q;
      else if (idx == RESULT_IDX)
        readdata_d[1:0] = result_q;
    end
  end
  always_comb
  begin
    chain_d  = chain_q;
    preset_d = preset_q;
    result_d = result_q;
    if (wr_acc && idx == CHAIN_IDX)
      chain_d = chain_t'(merge(chain_q, writedata, byteenable));
    if (wr_acc && idx == PRESET_IDX)
      preset_d = merge(preset_q, writedata, byteenable);
    if (exec_go)
      result_d = {(cmd.kind == KIND_SHIFT) & chain_bad,
                  (cmd.kind != KIND_SHIFT) & preset_bad};
  end

  // ********************************************************************
  // Counters
  // ********************************************************************
  always_comb
  begin
    logic [31:0] wv, nv;
    wv       = 32'h00000000;
    nv       = {16'h0000, cur16};
    vals_d   = vals_q;
    stat_d   = stat_q;
    prev_a_d = prev_a_q;
    prev_b_d = prev_b_q;
    if (wr_acc && in_win(idx, VALUE_BASE, COUNTERS))
    begin
      wv = merge({16'h0000, vals_q[voff[NW-1:0]]}, writedata, byteenable);
      vals_d[voff[NW-1:0]] = wv[15:0];
    end
    if (exec_ok)
    begin
      unique case (cmd.kind)
        KIND_BASIC:
        begin
          prev_a_d[n] = cmd.in_a;
          if (cmd.in_b)
            nv = 32'h00000000;
          else if (edge_a && cur16 < COUNT_MAX)
            nv = {16'h0000, cur16 + 16'h0001};
          vals_d[n] = nv[15:0];
          stat_d[n] = ~cmd.in_b & (nv >= preset_q);
        end
        KIND_STAGE:
        begin
          prev_a_d[n] = cmd.in_a;
          if (cmd.rst_cmd)
            nv = 32'h00000000;
          else if (edge_a && cur16 < COUNT_MAX)
            nv = {16'h0000, cur16 + 16'h0001};
          vals_d[n] = nv[15:0];
          stat_d[n] = ~cmd.rst_cmd & (nv >= preset_q);
        end
        KIND_UPDOWN:
        begin
          prev_a_d[n] = cmd.in_a;
          prev_b_d[n] = cmd.in_b;
          nv = cur32;
          // A tie of both edges fails both guards and holds the value.
          if (cmd.in_c)
            nv = 32'h00000000;
          else if (edge_a && !cmd.in_b && cur32 < UPDOWN_MAX)
            nv = cur32 + 32'h00000001;
          else if (edge_b && !cmd.in_a && cur32 != 32'h00000000)
            nv = cur32 - 32'h00000001;
          vals_d[n]  = nv[15:0];
          vals_d[n1] = nv[31:16];
          stat_d[n]  = ~cmd.in_c & (nv >= preset_q);
        end
        KIND_SHIFT: ;
      endcase
    end
  end

  // ********************************************************************
  // Shift chain
  // ********************************************************************
  always_comb
  begin
    relays_d   = relays_q;
    prev_clk_d = prev_clk_q;
    if (exec_ok && cmd.kind == KIND_SHIFT)
    begin
      prev_clk_d[f[RW-1:3]] = cmd.in_b;
      for (int i = 0; i < RELAYS; i++)
        if (RW'(i) >= lo && RW'(i) <= hi)
        begin
          if (cmd.in_c)
            relays_d[i] = 1'b0;
          else if (clk_edge && RW'(i) == entry)
            relays_d[i] = cmd.in_a;
          else if (clk_edge && up)
            relays_d[i] = relays_q[(i == 0) ? 0 : i - 1];
          else if (clk_edge)
            relays_d[i] = relays_q[(i == RELAYS - 1) ? i : i + 1];
        end
    end
  end

  // ********************************************************************
  // Registers
  // ********************************************************************
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      vals_q     <= '{default: VALUE_RST};
      stat_q     <= '0;
      prev_a_q   <= '0;
      prev_b_q   <= '0;
      relays_q   <= '0;
      prev_clk_q <= '0;
      chain_q    <= chain_t'(CHAIN_RST);
      preset_q   <= PRESET_RST;
      result_q   <= 2'h0;
      wait_q     <= 1'b1;
      readdata_q <= 32'h00000000;
    end
    else
    begin
      vals_q     <= vals_d;
      stat_q     <= stat_d;
      prev_a_q   <= prev_a_d;
      prev_b_q   <= prev_b_d;
      relays_q   <= relays_d;
      prev_clk_q <= prev_clk_d;
      chain_q    <= chain_d;
      preset_q   <= preset_d;
      result_q   <= result_d;
      wait_q     <= wait_d;
      readdata_q <= readdata_d;
    end
  end
  assign readdata    = readdata_q;
  assign waitrequest = wait_q;

  // ********************************************************************
  // Checks
  // ********************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence s_stage_go;
    exec_ok && cmd.kind == KIND_STAGE && !cmd.rst_cmd;
  endsequence
  sequence s_updown_go;
    exec_ok && cmd.kind == KIND_UPDOWN && !cmd.in_c;
  endsequence
  a_stage_step: assert property (
    s_stage_go ##0 (edge_a && cur16 < COUNT_MAX) |=>
      vals_q[$past(n)] == $past(cur16) + 16'h0001)
    else $error("Stage counter missed a count edge.");
  a_stage_keep: assert property (
    s_stage_go ##0 !edge_a |=> vals_q[$past(n)] == $past(cur16))
    else $error("Stage counter changed without an edge.");
  a_stage_clear: assert property (
    exec_ok && cmd.kind == KIND_STAGE && cmd.rst_cmd |=>
      vals_q[$past(n)] == 16'h0000 && !stat_q[$past(n)])
    else $error("Stage reset did not clear.");
  a_status_level: assert property (
    s_stage_go |=>
      stat_q[$past(n)] == ({16'h0000, vals_q[$past(n)]} >= $past(preset_q)))
    else $error("Status bit disagrees with value and preset.");
  a_count_cap: assert property (
    exec_ok && cmd.kind == KIND_BASIC && !cmd.in_b && cur16 == COUNT_MAX
      |=> vals_q[$past(n)] == COUNT_MAX)
    else $error("Counter passed its maximum.");
  a_basic_reset: assert property (
    exec_ok && cmd.kind == KIND_BASIC && cmd.in_b |=>
      vals_q[$past(n)] == 16'h0000 && !stat_q[$past(n)])
    else $error("Basic reset did not win.");
  a_updown_clear: assert property (
    exec_ok && cmd.kind == KIND_UPDOWN && cmd.in_c |=>
      {vals_q[$past(n1)], vals_q[$past(n)]} == 32'h00000000
      && !stat_q[$past(n)])
    else $error("Up/down reset did not clear.");
  a_updown_up: assert property (
    s_updown_go ##0 (edge_a && !cmd.in_b && cur32 < UPDOWN_MAX) |=>
      {vals_q[$past(n1)], vals_q[$past(n)]} == $past(cur32) + 32'h00000001)
    else $error("Up/down counter missed an up edge.");
  a_updown_tie: assert property (
    s_updown_go ##0 (edge_a && edge_b) |=>
      {vals_q[$past(n1)], vals_q[$past(n)]} == $past(cur32))
    else $error("Up/down counter moved on a tie.");
  a_shift_entry: assert property (
    exec_ok && cmd.kind == KIND_SHIFT && !cmd.in_c && clk_edge |=>
      relays_q[$past(entry)] == $past(writedata[16]))
    else $error("Shift data did not enter the chain.");
  a_preset_refuse: assert property (
    exec_go && cmd.kind != KIND_SHIFT && preset_bad |=>
      vals_q[$past(n)] == $past(cur16) && result_q[0])
    else $error("Out-of-range preset was not refused.");
  a_bus_answer: assert property (
    req && wait_q |=> !waitrequest ##1 waitrequest)
    else $error("Bus answer not given in one cycle.");

endmodule

/* hdl/counter_chain_pkg.sv */
// Purpose: Shared constants and carriers for the counter and shift unit.
// Assumes: Word indices below are register indices; byte address is 4x.
// Notes:   Counter words and status words sit at the controller's own
//          word-memory locations so software sees the same map.

package counter_chain_pkg;

  // ********************************************************************
  // Sizes and limits
  // ********************************************************************
  localparam int unsigned NUM_COUNTERS = 128;
  localparam int unsigned NUM_RELAYS   = 1024;
  localparam logic [15:0] COUNT_MAX    = 16'h270f;
  localparam logic [31:0] UPDOWN_MAX   = 32'h05f5e0ff;

  // ********************************************************************
  // Register indices
  // ********************************************************************
  localparam logic [14:0] VALUE_BASE   = 15'h0200;
  localparam logic [14:0] STATUS_BASE  = 15'h4260;
  localparam logic [14:0] RELAY_BASE   = 15'h0300;
  localparam logic [14:0] CMD_IDX      = 15'h0100;
  localparam logic [14:0] CHAIN_IDX    = 15'h0101;
  localparam logic [14:0] PRESET_IDX   = 15'h0102;
  localparam logic [14:0] RESULT_IDX   = 15'h0103;

  // ********************************************************************
  // Reset values
  // ********************************************************************
  localparam logic [31:0] PRESET_RST   = 32'h00000000;
  localparam logic [31:0] CHAIN_RST    = 32'h00000000;
  localparam logic [15:0] VALUE_RST    = 16'h0000;

  typedef enum logic [1:0] {
    KIND_BASIC  = 2'h0,
    KIND_STAGE  = 2'h1,
    KIND_UPDOWN = 2'h2,
    KIND_SHIFT  = 2'h3
  } op_kind_t;

  typedef struct packed {
    logic [9:0] spare_hi;
    logic       rst_cmd;
    logic       preset_word;
    logic       spare_m;
    logic       in_c;
    logic       in_b;
    logic       in_a;
    logic [4:0] spare_l;
    logic [6:0] num;
    logic [1:0] spare_k;
    op_kind_t   kind;
  } cmd_t;

  typedef struct packed {
    logic [5:0] spare_hi;
    logic [9:0] last;
    logic [5:0] spare_lo;
    logic [9:0] first;
  } chain_t;

endpackage

/* verif/counter_and_shift_chain_unit_bench.sv */
// Purpose: Self-checking bench for the counter and shift chain unit.
// Assumes: One wait state per access; one command write is one scan step.
// Notes:   Expected values are worked out by hand from the counting rules.

`timescale 1ns/1ps

module counter_and_shift_chain_unit_bench
  import counter_chain_pkg::*;
;
  logic        clock;
  logic        reset_n;
  logic [16:0] address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  int          err_total;
  int          check_count;
  int          cycles;

  counter_and_shift_chain_unit uut (
    .clock       (clock),
    .reset_n     (reset_n),
    .address     (address),
    .read        (read),
    .write       (write),
    .writedata   (writedata),
    .byteenable  (byteenable),
    .readdata    (readdata),
    .waitrequest (waitrequest)
  );

  // ******************************************************************
  // Clock, reset values and hang guard
  // ******************************************************************
  initial
  begin
    clock = 1'b0;
    reset_n = 1'b0;
    address = 17'h0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'hf;
    err_total = 0;
    check_count = 0;
    cycles = 0;
  end

  always #2.5 clock = ~clock;

  // The whole run needs well under a tenth of this ceiling.
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_total++;
      complete_run();
    end
  end

  // ******************************************************************
  // Bus and compare tasks
  // ******************************************************************
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic xfer(input logic rw, input logic [14:0] idx,
                      input logic [31:0] d, input logic [3:0] be,
                      output logic [31:0] q);
    @(posedge clock);
    address <= {idx, 2'h0};
    read <= !rw;
    write <= rw;
    writedata <= d;
    byteenable <= be;
    do @(posedge clock); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic check(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [14:0] idx, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, idx, d, 4'hf, q);
  endtask

  task automatic rd(input string nm, input logic [14:0] idx,
                    input logic [31:0] exp,
                    input logic [31:0] msk = 32'hffffffff);
    logic [31:0] q;
    xfer(1'b0, idx, 32'h0, 4'hf, q);
    check(nm, exp, q & msk);
  endtask

  function automatic logic [31:0] mk(op_kind_t k, logic [6:0] n, logic a,
                                     logic b, logic c, logic rc);
    cmd_t m;
    m = '0;
    m.kind = k;
    m.num = n;
    m.in_a = a;
    m.in_b = b;
    m.in_c = c;
    m.rst_cmd = rc;
    return m;
  endfunction

  task automatic op(op_kind_t k, logic [6:0] n, logic a, logic b,
                    logic c, logic rc = 1'b0);
    wr(CMD_IDX, mk(k, n, a, b, c, rc));
  endtask

  // ******************************************************************
  // Tests
  // ******************************************************************
  initial
  begin
    logic [31:0] q;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    rd("value0", VALUE_BASE, {16'h0, VALUE_RST});
    rd("status0", STATUS_BASE, 32'h0);
    rd("preset", PRESET_IDX, PRESET_RST);
    rd("unmapped", 15'h7000, 32'h0);
    $display("test reset done");

    wr(PRESET_IDX, 32'h2);
    op(KIND_BASIC, 7'h3, 1'b1, 1'b0, 1'b0);
    rd("basic", VALUE_BASE + 15'h3, 32'h1);
    rd("st_low", STATUS_BASE, 32'h0, 32'h8);
    op(KIND_BASIC, 7'h3, 1'b1, 1'b0, 1'b0);
    rd("basic_lvl", VALUE_BASE + 15'h3, 32'h1);
    op(KIND_BASIC, 7'h3, 1'b0, 1'b0, 1'b0);
    op(KIND_BASIC, 7'h3, 1'b1, 1'b0, 1'b0);
    rd("basic2", VALUE_BASE + 15'h3, 32'h2);
    rd("st_eq", STATUS_BASE, 32'h8, 32'h8);
    op(KIND_BASIC, 7'h3, 1'b0, 1'b0, 1'b0);
    op(KIND_BASIC, 7'h3, 1'b1, 1'b1, 1'b0);
    rd("basic_rst", VALUE_BASE + 15'h3, 32'h0);
    rd("st_rst", STATUS_BASE, 32'h0, 32'h8);
    op(KIND_BASIC, 7'h3, 1'b0, 1'b0, 1'b0);
    wr(PRESET_IDX, 32'h2710);
    op(KIND_BASIC, 7'h3, 1'b1, 1'b0, 1'b0);
    rd("bad_pre", RESULT_IDX, 32'h1);
    rd("bad_val", VALUE_BASE + 15'h3, 32'h0);
    wr(CMD_IDX, mk(KIND_BASIC, 7'h3, 1'b0, 1'b0, 1'b0, 1'b0)
       | 32'h00100000);
    rd("word_pre", RESULT_IDX, 32'h0);
    wr(PRESET_IDX, 32'h270f);
    op(KIND_BASIC, 7'h3, 1'b0, 1'b0, 1'b0);
    op(KIND_BASIC, 7'h3, 1'b1, 1'b0, 1'b0);
    rd("max_pre", RESULT_IDX, 32'h0);
    op(KIND_BASIC, 7'h3, 1'b0, 1'b0, 1'b0);
    xfer(1'b1, CMD_IDX, mk(KIND_BASIC, 7'h3, 1'b1, 1'b0, 1'b0, 1'b0),
         4'h3, q);
    rd("part_be", VALUE_BASE + 15'h3, 32'h1);
    wr(VALUE_BASE + 15'h3, {16'h0, COUNT_MAX});
    op(KIND_BASIC, 7'h3, 1'b1, 1'b0, 1'b0);
    rd("basic_sat", VALUE_BASE + 15'h3, {16'h0, COUNT_MAX});
    $display("test basic done");

    wr(PRESET_IDX, 32'h1);
    op(KIND_STAGE, 7'h7, 1'b1, 1'b0, 1'b0);
    rd("stage", VALUE_BASE + 15'h7, 32'h1);
    rd("st_stage", STATUS_BASE, 32'h80, 32'h80);
    op(KIND_STAGE, 7'h7, 1'b0, 1'b1, 1'b1);
    rd("stage_hold", VALUE_BASE + 15'h7, 32'h1);
    wr(VALUE_BASE + 15'h7, {16'h0, COUNT_MAX - 16'h1});
    op(KIND_STAGE, 7'h7, 1'b1, 1'b0, 1'b0);
    rd("stage_max", VALUE_BASE + 15'h7, 32'h270f);
    op(KIND_STAGE, 7'h7, 1'b0, 1'b0, 1'b0);
    op(KIND_STAGE, 7'h7, 1'b1, 1'b0, 1'b0);
    rd("stage_sat", VALUE_BASE + 15'h7, 32'h270f);
    op(KIND_STAGE, 7'h7, 1'b0, 1'b0, 1'b0, 1'b1);
    rd("stage_clr", VALUE_BASE + 15'h7, 32'h0);
    rd("st_clr", STATUS_BASE, 32'h0, 32'h80);
    $display("test stage done");

    wr(PRESET_IDX, 32'h3);
    op(KIND_UPDOWN, 7'ha, 1'b1, 1'b0, 1'b0);
    op(KIND_UPDOWN, 7'ha, 1'b0, 1'b0, 1'b0);
    op(KIND_UPDOWN, 7'ha, 1'b1, 1'b0, 1'b0);
    rd("ud_up", VALUE_BASE + 15'ha, 32'h2);
    op(KIND_UPDOWN, 7'ha, 1'b0, 1'b0, 1'b0);
    op(KIND_UPDOWN, 7'ha, 1'b0, 1'b1, 1'b0);
    rd("ud_down", VALUE_BASE + 15'ha, 32'h1);
    op(KIND_UPDOWN, 7'ha, 1'b0, 1'b0, 1'b0);
    op(KIND_UPDOWN, 7'ha, 1'b1, 1'b1, 1'b0);
    rd("ud_both", VALUE_BASE + 15'ha, 32'h1);
    op(KIND_UPDOWN, 7'ha, 1'b0, 1'b0, 1'b0);
    wr(VALUE_BASE + 15'ha, 32'hffff);
    wr(VALUE_BASE + 15'hb, 32'h0);
    op(KIND_UPDOWN, 7'ha, 1'b1, 1'b0, 1'b0);
    rd("ud_lo", VALUE_BASE + 15'ha, 32'h0);
    rd("ud_hi", VALUE_BASE + 15'hb, 32'h1);
    rd("st_ud", STATUS_BASE, 32'h400, 32'h400);
    op(KIND_UPDOWN, 7'ha, 1'b0, 1'b0, 1'b1);
    rd("ud_rlo", VALUE_BASE + 15'ha, 32'h0);
    rd("ud_rhi", VALUE_BASE + 15'hb, 32'h0);
    rd("st_udr", STATUS_BASE, 32'h0, 32'h400);
    op(KIND_UPDOWN, 7'ha, 1'b1, 1'b0, 1'b1);
    rd("ud_rwin", VALUE_BASE + 15'ha, 32'h0);
    wr(PRESET_IDX, UPDOWN_MAX + 32'h1);
    op(KIND_UPDOWN, 7'ha, 1'b0, 1'b0, 1'b0);
    rd("ud_bad", RESULT_IDX, 32'h1);
    $display("test updown done");

    wr(CHAIN_IDX, 32'h00170008);
    op(KIND_SHIFT, 7'h0, 1'b1, 1'b1, 1'b0);
    op(KIND_SHIFT, 7'h0, 1'b0, 1'b0, 1'b0);
    op(KIND_SHIFT, 7'h0, 1'b0, 1'b1, 1'b0);
    op(KIND_SHIFT, 7'h0, 1'b1, 1'b0, 1'b0);
    op(KIND_SHIFT, 7'h0, 1'b1, 1'b1, 1'b0);
    rd("chain_ok", RESULT_IDX, 32'h0);
    rd("sh_up", RELAY_BASE, 32'h0500);
    wr(RELAY_BASE, 32'hffff);
    rd("relay_ro", RELAY_BASE, 32'h0500);
    wr(CHAIN_IDX, 32'h00080017);
    op(KIND_SHIFT, 7'h0, 1'b1, 1'b1, 1'b0);
    rd("sh_dn0", RELAY_BASE, 32'h0200);
    rd("sh_dn1", RELAY_BASE + 15'h1, 32'h0080);
    op(KIND_SHIFT, 7'h0, 1'b0, 1'b0, 1'b1);
    rd("sh_rst0", RELAY_BASE, 32'h0);
    rd("sh_rst1", RELAY_BASE + 15'h1, 32'h0);
    wr(CHAIN_IDX, 32'h00170009);
    op(KIND_SHIFT, 7'h0, 1'b0, 1'b0, 1'b0);
    rd("bad_lo", RESULT_IDX, 32'h2);
    wr(CHAIN_IDX, 32'h00160008);
    op(KIND_SHIFT, 7'h0, 1'b0, 1'b0, 1'b0);
    rd("bad_hi", RESULT_IDX, 32'h2);
    $display("test shift done");
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    rd("rst_val", VALUE_BASE + 15'h3, {16'h0, VALUE_RST});
    rd("rst_chain", CHAIN_IDX, CHAIN_RST);
    rd("rst_pre", PRESET_IDX, PRESET_RST);
    $display("test reset again done");
    complete_run();
  end
endmodule
